// >>> rtl/power_ctl_consts.svh
// Timing constants and counter width for the host power controller
`ifndef POWER_CTL_CONSTS_SVH
`define POWER_CTL_CONSTS_SVH
`define CLK_FREQ_HZ 40000000
`define START_PRESS_MS 150
`define SHUTDOWN_HOLD_MS 2000
`define FORCE_HOLD_MS 5000
`define RESTART_WAIT_MS 30000
`define DEBOUNCE_US 10000
`define BLINK_HALF_MS 250
`define PULSE_US 10000
`define MS_CYCLES(ms) ((ms) * (`CLK_FREQ_HZ / 1000))
`define US_CYCLES(us) ((us) * (`CLK_FREQ_HZ / 1000000))
`define START_PRESS_CYC `MS_CYCLES(`START_PRESS_MS)
`define SHUTDOWN_HOLD_CYC `MS_CYCLES(`SHUTDOWN_HOLD_MS)
`define FORCE_HOLD_CYC `MS_CYCLES(`FORCE_HOLD_MS)
`define RESTART_WAIT_CYC `MS_CYCLES(`RESTART_WAIT_MS)
`define DEBOUNCE_CYC `US_CYCLES(`DEBOUNCE_US)
`define BLINK_HALF_CYC `MS_CYCLES(`BLINK_HALF_MS)
`define PULSE_CYC `US_CYCLES(`PULSE_US)
`define CNT_W 32
`endif

// >>> rtl/power_ctl_pkg.sv
// Types shared by the host power controller
package power_ctl_pkg;
  typedef enum logic [5:0] {
    ST_INIT      = 6'h01,
    ST_OFF       = 6'h02,
    ST_WAIT_UP   = 6'h04,
    ST_ON        = 6'h08,
    ST_WAIT_DOWN = 6'h10,
    ST_WAIT_RET  = 6'h20
  } power_state_e;
endpackage

// >>> rtl/button_if.sv
// Debounced button hold events passed from the timer to the state machine
interface button_if;
  logic pressed;
  logic startHit;
  logic shutdownHit;
  logic forceHit;
  modport timer (output pressed, output startHit, output shutdownHit, output forceHit);
  modport fsm (input pressed, input startHit, input shutdownHit, input forceHit);
endinterface : button_if

// >>> rtl/button_timer.sv
// Button debounce and hold-time threshold detector
`include "power_ctl_consts.svh"
module button_timer
  import power_ctl_pkg::*;
#(
  parameter logic [31:0] DEBOUNCE_CYC = `DEBOUNCE_CYC,
  parameter logic [31:0] START_CYC = `START_PRESS_CYC,
  parameter logic [31:0] SHUTDOWN_CYC = `SHUTDOWN_HOLD_CYC,
  parameter logic [31:0] FORCE_CYC = `FORCE_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic buttonSync,
  button_if.timer btn
);
  logic [31:0] bounceCnt_r;
  logic [31:0] holdCnt_r;
  logic stable_r;

  // Level must hold unchanged for the whole window before it is believed
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bounceCnt_r <= 32'h0;
      stable_r <= 1'b0;
    end else if (buttonSync == stable_r) begin
      bounceCnt_r <= 32'h0;
    end else if (bounceCnt_r >= DEBOUNCE_CYC - 32'h1) begin
      bounceCnt_r <= 32'h0;
      stable_r <= buttonSync;
    end else begin
      bounceCnt_r <= bounceCnt_r + 32'h1;
    end
  end

  // Saturating hold counter; each threshold fires once per press
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      holdCnt_r <= 32'h0;
    end else if (!stable_r) begin
      holdCnt_r <= 32'h0;
    end else if (holdCnt_r != 32'hFFFFFFFF) begin
      holdCnt_r <= holdCnt_r + 32'h1;
    end
  end

  assign btn.pressed = stable_r;
  assign btn.startHit = stable_r && (holdCnt_r == START_CYC - 32'h1);
  assign btn.shutdownHit = stable_r && (holdCnt_r == SHUTDOWN_CYC - 32'h1);
  assign btn.forceHit = stable_r && (holdCnt_r == FORCE_CYC - 32'h1);
endmodule // button_timer

// >>> rtl/host_power_ctl.sv
// Host power controller: button handling, host alive watch, power and LED
//
// Behaviour
// - After supply arrives, start in initialise with host power off.
// - Press of 150 ms in initialise or off powers host, waits for it.
// - Waiting for host, move to on once alive line reads 1.
// - LED steadily lit while on.
// - Two-second hold while on requests shutdown, waits for host down.
// - Shutdown request is a pulse on the request line.
// - Alive line dropping while on goes to await host return.
// - Waiting for host down, alive low goes off, power removed.
// - LED blinks while awaiting host return.
// - Alive back within 30 s returns to on, power kept.
// - Alive still low after 30 s goes off, power cut.
// - Five-second hold outside initialise and off cuts power at once.
// - Off state: power removed, LED dark.
// - LED flashes during host reboot, steady once host is back.
`include "power_ctl_consts.svh"
module host_power_ctl
  import power_ctl_pkg::*;
#(
  parameter logic [31:0] DEBOUNCE_CYC = `DEBOUNCE_CYC,
  parameter logic [31:0] START_CYC = `START_PRESS_CYC,
  parameter logic [31:0] SHUTDOWN_CYC = `SHUTDOWN_HOLD_CYC,
  parameter logic [31:0] FORCE_CYC = `FORCE_HOLD_CYC,
  parameter logic [31:0] RESTART_CYC = `RESTART_WAIT_CYC,
  parameter logic [31:0] BLINK_CYC = `BLINK_HALF_CYC,
  parameter logic [31:0] PULSE_CYC = `PULSE_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic powerButton,
  input wire logic hostAliveLine,
  output logic hostPowerEn,
  output logic shutdownRequestLine,
  output logic statusLed
);
  power_state_e state_r;
  power_state_e state_nxt;
  logic [1:0] buttonMeta_r;
  logic [1:0] aliveMeta_r;
  logic [31:0] waitCnt_r;
  logic [31:0] blinkCnt_r;
  logic [31:0] pulseCnt_r;
  logic blink_r;
  logic pulseStart;
  button_if btn ();

  // Pins come from outside the clock domain
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      buttonMeta_r <= 2'h0;
      aliveMeta_r <= 2'h0;
    end else begin
      buttonMeta_r <= {buttonMeta_r[0], powerButton};
      aliveMeta_r <= {aliveMeta_r[0], hostAliveLine};
    end
  end

  button_timer #(
    .DEBOUNCE_CYC(DEBOUNCE_CYC),
    .START_CYC(START_CYC),
    .SHUTDOWN_CYC(SHUTDOWN_CYC),
    .FORCE_CYC(FORCE_CYC)
  ) u_timer (
    .mclk(mclk),
    .reset(reset),
    .buttonSync(buttonMeta_r[1]),
    .btn(btn)
  );

  function automatic logic hostAlive(input logic [1:0] sync);
    return sync[1];
  endfunction

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT, ST_OFF: begin
        if (btn.startHit) begin
          state_nxt = ST_WAIT_UP;
        end
      end
      ST_WAIT_UP: begin
        if (btn.forceHit) begin
          state_nxt = ST_OFF;
        end else if (hostAlive(aliveMeta_r)) begin
          state_nxt = ST_ON;
        end
      end
      ST_ON: begin
        if (btn.forceHit) begin
          state_nxt = ST_OFF;
        end else if (btn.shutdownHit) begin
          state_nxt = ST_WAIT_DOWN;
        end else if (!hostAlive(aliveMeta_r)) begin
          state_nxt = ST_WAIT_RET;
        end
      end
      ST_WAIT_DOWN: begin
        if (btn.forceHit) begin
          state_nxt = ST_OFF;
        end else if (!hostAlive(aliveMeta_r)) begin
          state_nxt = ST_OFF;
        end
      end
      ST_WAIT_RET: begin
        if (btn.forceHit) begin
          state_nxt = ST_OFF;
        end else if (hostAlive(aliveMeta_r)) begin
          state_nxt = ST_ON;
        end else if (waitCnt_r >= RESTART_CYC - 32'h1) begin
          state_nxt = ST_OFF;
        end
      end
      default: begin
        state_nxt = ST_INIT;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r <= ST_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Restart window counts from entry into await host return
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      waitCnt_r <= 32'h0;
    end else if (state_r != ST_WAIT_RET) begin
      waitCnt_r <= 32'h0;
    end else begin
      waitCnt_r <= waitCnt_r + 32'h1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      blinkCnt_r <= 32'h0;
      blink_r <= 1'b0;
    end else if (state_r != ST_WAIT_RET) begin
      blinkCnt_r <= 32'h0;
      blink_r <= 1'b1;
    end else if (blinkCnt_r >= BLINK_CYC - 32'h1) begin
      blinkCnt_r <= 32'h0;
      blink_r <= ~blink_r;
    end else begin
      blinkCnt_r <= blinkCnt_r + 32'h1;
    end
  end

  // One request pulse on entering await host down
  assign pulseStart = (state_r == ST_ON) && (state_nxt == ST_WAIT_DOWN);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pulseCnt_r <= 32'h0;
      shutdownRequestLine <= 1'b0;
    end else if (pulseStart) begin
      pulseCnt_r <= PULSE_CYC - 32'h1;
      shutdownRequestLine <= 1'b1;
    end else if (pulseCnt_r != 32'h0) begin
      pulseCnt_r <= pulseCnt_r - 32'h1;
    end else begin
      shutdownRequestLine <= 1'b0;
    end
  end

  // Power follows the next state so a force cut takes effect at once
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hostPowerEn <= 1'b0;
    end else begin
      hostPowerEn <= (state_nxt != ST_INIT) && (state_nxt != ST_OFF);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      statusLed <= 1'b0;
    end else begin
      case (state_r)
        ST_ON: statusLed <= 1'b1;
        ST_WAIT_RET: statusLed <= blink_r;
        default: statusLed <= 1'b0;
      endcase
    end
  end
endmodule // host_power_ctl

// >>> sim/host_power_ctl_props.sv
// Port-level assertions for the host power controller
module host_power_ctl_props (
  input wire logic mclk,
  input wire logic reset,
  input wire logic powerButton,
  input wire logic hostAliveLine,
  input wire logic hostPowerEn,
  input wire logic shutdownRequestLine,
  input wire logic statusLed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] holdCnt;
  logic [7:0] lowCnt;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset || !powerButton) holdCnt <= 8'h00;
    else if (holdCnt != 8'hFF) holdCnt <= holdCnt + 8'h01;
  end
  // Counts only unattended host-down time, so the timeout check can use a window of 1 to 18 cycles
  always_ff @(posedge mclk or posedge reset) begin
    if (reset || !hostPowerEn || hostAliveLine || powerButton) lowCnt <= 8'h00;
    else if (lowCnt != 8'hFF) lowCnt <= lowCnt + 8'h01;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_init_off; $fell(reset) |-> !hostPowerEn && !statusLed; endproperty
  a_init_off: assert property (p_init_off) else $error("outputs active after reset");
  property p_start; $rose(hostPowerEn) |-> $past(powerButton, 2) && $past(powerButton, 12);
  endproperty
  a_start: assert property (p_start) else $error("power on without long press");
  property p_req_width;
    $rose(shutdownRequestLine) |=> shutdownRequestLine [*4] ##1 !shutdownRequestLine;
  endproperty
  a_req_width: assert property (p_req_width) else $error("request pulse width");
  property p_req_cause; $rose(shutdownRequestLine) |-> hostPowerEn && $past(powerButton, 2);
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("request without hold");
  property p_dark; !hostPowerEn && !$past(hostPowerEn) |-> !statusLed; endproperty
  a_dark: assert property (p_dark) else $error("led lit while off");
  property p_force; holdCnt == 8'd100 |-> !hostPowerEn; endproperty
  a_force: assert property (p_force) else $error("long hold left power on");
  property p_blink; $rose(statusLed) && !hostAliveLine |=> statusLed [*4]; endproperty
  a_blink: assert property (p_blink) else $error("blink half period short");
  property p_drop; $fell(hostPowerEn) |-> !$past(hostAliveLine, 2) || $past(powerButton, 2);
  endproperty
  a_drop: assert property (p_drop) else $error("power cut while host alive");
  property p_timeout; lowCnt == 8'd192 |-> ##[1:18] !hostPowerEn; endproperty
  a_timeout: assert property (p_timeout) else $error("restart wait not timed out");
  c_req: cover property ($rose(shutdownRequestLine));
  c_forced: cover property ($fell(hostPowerEn) && hostAliveLine);
  c_wait: cover property (lowCnt == 8'd192);
endmodule // host_power_ctl_props
bind host_power_ctl host_power_ctl_props props (.mclk(mclk), .reset(reset),
  .powerButton(powerButton), .hostAliveLine(hostAliveLine), .hostPowerEn(hostPowerEn),
  .shutdownRequestLine(shutdownRequestLine), .statusLed(statusLed));

// >>> sim/host_model.sv
// Behavioural host computer: boots, reboots, honours shutdown pulses
module host_model (
  input wire logic mclk,
  input wire logic hostPowerEn,
  input wire logic shutdownRequestLine,
  input wire logic rebootCmd,
  input wire logic deaf,
  input wire logic [7:0] bootDelay,
  output logic hostAliveLine
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bootCnt_r;
  logic halted_r;
  always @(posedge mclk) begin
    // Unpowered host drives nothing; line is pulled low
    if (hostPowerEn !== 1'b1) begin
      hostAliveLine <= 1'b0;
      bootCnt_r <= 8'h00;
      halted_r <= 1'b0;
    end else if ((shutdownRequestLine && !deaf) || rebootCmd) begin
      hostAliveLine <= 1'b0;
      bootCnt_r <= 8'h00;
      halted_r <= !rebootCmd;
    end else if (!halted_r && !hostAliveLine) begin
      bootCnt_r <= bootCnt_r + 8'h01;
      hostAliveLine <= (bootCnt_r == bootDelay);
    end
  end
endmodule // host_model

// >>> sim/host_power_ctl_bench.sv
// Self-checking bench for the host power controller
module host_power_ctl_bench import power_ctl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, reset = 1'b1, powerButton = 1'b0, rebootCmd = 1'b0, deaf = 1'b0;
  logic hostAliveLine, hostPowerEn, shutdownRequestLine, statusLed, sawReq = 1'b0;
  logic [7:0] bootDelay = 8'h10;
  int errorCnt = 0, totalChecks = 0, seed = 32'h0D65, n;
  // Shortened timings so every threshold is reached within the run
  localparam logic [31:0] SIM_DEBOUNCE = 32'h4;
  localparam logic [31:0] SIM_START = 32'hA;
  localparam logic [31:0] SIM_SHUTDOWN = 32'h28;
  localparam logic [31:0] SIM_FORCE = 32'h50;
  localparam logic [31:0] SIM_RESTART = 32'hC8;
  localparam logic [31:0] SIM_BLINK = 32'h8;
  localparam logic [31:0] SIM_PULSE = 32'h5;
  initial forever #12.5 mclk = ~mclk;
  host_power_ctl #(.DEBOUNCE_CYC(SIM_DEBOUNCE), .START_CYC(SIM_START),
    .SHUTDOWN_CYC(SIM_SHUTDOWN), .FORCE_CYC(SIM_FORCE), .RESTART_CYC(SIM_RESTART),
    .BLINK_CYC(SIM_BLINK), .PULSE_CYC(SIM_PULSE)) dut (.mclk(mclk), .reset(reset),
    .powerButton(powerButton), .hostAliveLine(hostAliveLine), .hostPowerEn(hostPowerEn),
    .shutdownRequestLine(shutdownRequestLine), .statusLed(statusLed));
  host_model host (.mclk(mclk), .hostPowerEn(hostPowerEn), .rebootCmd(rebootCmd),
    .shutdownRequestLine(shutdownRequestLine), .deaf(deaf), .bootDelay(bootDelay),
    .hostAliveLine(hostAliveLine));
  always @(posedge mclk) if (shutdownRequestLine === 1'b1) sawReq <= 1'b1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic hold(input int cyc);
    @(negedge mclk);
    powerButton = 1'b1;
    repeat (cyc) @(negedge mclk);
    powerButton = 1'b0;
  endtask
  task automatic waitPow(input logic v, output int t);
    t = 0;
    while (hostPowerEn !== v && t < 400) begin
      @(negedge mclk);
      t++;
    end
  endtask
  task automatic powerUp;
    // Release long enough for the debounce to see the button up
    repeat (10) @(negedge mclk);
    hold(20);
    waitPow(1'b1, n);
    check(hostPowerEn, 1'b1);
    repeat (bootDelay + 10) @(negedge mclk);
    check(statusLed, 1'b1);
  endtask
  task automatic rebootPulse;
    rebootCmd = 1'b1;
    @(negedge mclk);
    rebootCmd = 1'b0;
  endtask
  task automatic stopTest;
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(25 * 5000);
    errorCnt++;
    stopTest;
  end
  initial begin
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    check(hostPowerEn, 1'b0);
    repeat (6) begin
      n = $random(seed);
      hold(1 + (n & 7));
      repeat (20) @(negedge mclk);
      check(hostPowerEn, 1'b0);
    end
    n = $random(seed);
    bootDelay = 8'(16 + (n & 31));
    powerUp;
    repeat (20) begin
      @(negedge mclk);
      check(statusLed, 1'b1);
    end
    rebootPulse;
    n = 0;
    repeat (bootDelay) begin
      @(negedge mclk);
      n += (statusLed === 1'b0);
    end
    check(n > 0, 1'b1);
    repeat (10) @(negedge mclk);
    check({hostPowerEn, statusLed}, 2'h3);
    bootDelay = 8'hFA;
    rebootPulse;
    waitPow(1'b0, n);
    check(n >= SIM_RESTART && n <= SIM_RESTART + 6, 1'b1);
    repeat (3) @(negedge mclk);
    check(statusLed, 1'b0);
    bootDelay = 8'h08;
    powerUp;
    sawReq = 1'b0;
    hold(60);
    check(sawReq, 1'b1);
    check(hostPowerEn, 1'b0);
    powerUp;
    deaf = 1'b1;
    hold(120);
    check(hostPowerEn, 1'b0);
    stopTest;
  end
endmodule // host_power_ctl_bench
